// file: core/msf_regs.svh
// special function register addresses, reset values and codes
`ifndef MSF_REGS_SVH
`define MSF_REGS_SVH
// ****************************************
// register addresses
// ****************************************
`define MSF_A_P0 8'h80
`define MSF_A_SP 8'h81
`define MSF_A_DPL0 8'h82
`define MSF_A_DPH0 8'h83
`define MSF_A_DATA_PTR1_LOW 8'h84
`define MSF_A_DATA_PTR1_HIGH 8'h85
`define MSF_A_WDREL 8'h86
`define MSF_A_POWER_SPEED_CONTROL 8'h87
`define MSF_A_TCTL 8'h88
`define MSF_A_TMODE 8'h89
`define MSF_A_T0L 8'h8A
`define MSF_A_T1L 8'h8B
`define MSF_A_T0H 8'h8C
`define MSF_A_T1H 8'h8D
`define MSF_A_STRETCH 8'h8E
`define MSF_A_P1 8'h90
`define MSF_A_PORT1_DIRECTION 8'h91
`define MSF_A_DSEL 8'h92
`define MSF_A_ERASE 8'h94
`define MSF_A_S0CTL 8'h98
`define MSF_A_S0DAT 8'h99
`define MSF_A_IE2 8'h9A
`define MSF_A_S1CTL 8'h9B
`define MSF_A_S1DAT 8'h9C
`define MSF_A_S1RL 8'h9D
`define MSF_A_EEDAT 8'h9E
`define MSF_A_EECMD 8'h9F
`define MSF_A_P2 8'hA0
`define MSF_A_PORT2_DIRECTION 8'hA1
`define MSF_A_PORT0_DIRECTION 8'hA2
`define MSF_A_IE0 8'hA8
`define MSF_A_IP0 8'hA9
`define MSF_A_S0RL 8'hAA
`define MSF_A_FCTL 8'hB2
`define MSF_A_PGSEL 8'hB7
`define MSF_A_IE1 8'hB8
`define MSF_A_IP1 8'hB9
`define MSF_A_S0RH 8'hBA
`define MSF_A_S1RH 8'hBB
`define MSF_A_MPAGE 8'hBF
`define MSF_A_IRQF 8'hC0
`define MSF_A_PSW 8'hD0
`define MSF_A_BAUD 8'hD8
`define MSF_A_ACC 8'hE0
`define MSF_A_WDIF 8'hE8
`define MSF_A_BREG 8'hF0
`define MSF_A_XINT 8'hF8
// ****************************************
// reset values, others reset to zero
// ****************************************
`define MSF_R_PORT 8'hFF
`define MSF_R_P2 8'h00
`define MSF_R_SP 8'h07
`define MSF_R_STRETCH 8'h01
`define MSF_R_S0RL 8'hD9
`define MSF_R_RH 8'h03
`define MSF_R_ZERO 8'h00
// ****************************************
// field positions and command codes
// ****************************************
`define MSF_F_PWE 0
`define MSF_F_MEEN 1
`define MSF_F_SEC 6
`define MSF_F_PRE 7
`define MSF_F_WDRST 7
`define MSF_F_GIE 7
`define MSF_F_RS_LO 3
`define MSF_F_RS_HI 4
`define MSF_C_PAGE 8'h55
`define MSF_C_MASS 8'hAA
`define MSF_C_EETX 8'h01
`endif

// file: core/msf_pkg.sv
// types of the special function register bank
`include "msf_regs.svh"
package msf_pkg;
  localparam int MSF_NGEN = 39; // plain storage registers
  typedef struct packed {
    logic [MSF_NGEN-1:0][7:0] gen;
    logic [2:0][7:0] port;
    logic [2:0][7:0] pin_m;
    logic [2:0][7:0] pin_s;
    logic [6:0] int_m;
    logic [6:0] int_s;
    logic dbg_m;
    logic dbg_s;
    logic [7:0] sp;
    logic [15:0] pc;
    logic pwe;
    logic meen;
    logic sec;
    logic pg_ok;
    logic [1:0] watchdog_irq_flags;
    logic page_go;
    logic mass_go;
    logic ee_go;
    logic wd_go;
    logic [7:0] rdata;
    logic rvalid;
    logic [6:0] epage;
  } msf_state_t;
endpackage

// file: core/msf_sfr_bank.sv
// special function register bank of the 8-bit processor core
`timescale 1ns/1ps
`default_nettype none
`include "msf_regs.svh"
module msf_sfr_bank
  import msf_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_bit_wr,
  input wire logic [2:0] sfr_bit_sel,
  input wire logic sfr_bit_val,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic pc_fetch,
  input wire logic pc_load,
  input wire logic [15:0] pc_load_val,
  input wire logic dptr_ext_wr,
  input wire logic engine_transfer_event,
  input wire logic one_second_event,
  input wire logic preboot_active,
  input wire logic debug_port_en,
  input wire logic [6:0] ext_int_pins,
  input wire logic [7:0] port0_pins,
  input wire logic [7:0] port1_pins,
  input wire logic [7:0] port2_pins,
  output logic [7:0] port0_out,
  output logic [7:0] port1_out,
  output logic [7:0] port2_out,
  output logic [7:0] port0_oe_n,
  output logic [7:0] port1_oe_n,
  output logic [7:0] port2_oe_n,
  output logic [7:0] stack_pointer,
  output logic [15:0] program_counter,
  output logic [7:0] bank_base,
  output logic [15:0] active_dptr,
  output logic program_write_enable,
  output logic read_protect_lock,
  output logic page_erase_start,
  output logic mass_erase_start,
  output logic [6:0] erase_page,
  output logic eeprom_start,
  output logic [7:0] eeprom_byte_data,
  output logic [7:0] eeprom_command,
  output logic watchdog_restart
);
  // ****************************************
  // storage map and reset image
  // ****************************************
  localparam logic [7:0] GEN_ADDR [MSF_NGEN] = '{
    `MSF_A_DPL0, `MSF_A_DPH0, `MSF_A_DATA_PTR1_LOW, `MSF_A_DATA_PTR1_HIGH,
    `MSF_A_WDREL, `MSF_A_POWER_SPEED_CONTROL, `MSF_A_TCTL, `MSF_A_TMODE,
    `MSF_A_T0L, `MSF_A_T1L, `MSF_A_T0H, `MSF_A_T1H,
    `MSF_A_STRETCH, `MSF_A_PORT1_DIRECTION, `MSF_A_DSEL, `MSF_A_S0CTL,
    `MSF_A_S0DAT, `MSF_A_IE2, `MSF_A_S1CTL, `MSF_A_S1DAT,
    `MSF_A_S1RL, `MSF_A_EEDAT, `MSF_A_EECMD, `MSF_A_PORT2_DIRECTION,
    `MSF_A_PORT0_DIRECTION, `MSF_A_IE0, `MSF_A_IP0, `MSF_A_S0RL,
    `MSF_A_PGSEL, `MSF_A_IE1, `MSF_A_IP1, `MSF_A_S0RH,
    `MSF_A_S1RH, `MSF_A_MPAGE, `MSF_A_IRQF, `MSF_A_PSW,
    `MSF_A_BAUD, `MSF_A_ACC, `MSF_A_BREG
  };

  // position of an address in the storage array, -1 if none
  function automatic int gidx(input logic [7:0] a);
    int r;
    r = -1;
    for (int i = 0; i < MSF_NGEN; i++) begin
      if (GEN_ADDR[i] == a) begin
        r = i;
      end
    end
    return r;
  endfunction

  // per-address reset value of a storage register
  function automatic logic [7:0] grst(input logic [7:0] a);
    logic [7:0] v;
    v = `MSF_R_ZERO;
    if (a == `MSF_A_STRETCH) begin
      v = `MSF_R_STRETCH;
    end
    if (a == `MSF_A_S0RL) begin
      v = `MSF_R_S0RL;
    end
    if (a == `MSF_A_S0RH || a == `MSF_A_S1RH) begin
      v = `MSF_R_RH;
    end
    return v;
  endfunction

  // whole reset image built from constants only
  function automatic msf_state_t rst_image();
    msf_state_t r;
    r = '0;
    for (int i = 0; i < MSF_NGEN; i++) begin
      r.gen[i] = grst(GEN_ADDR[i]);
    end
    r.port[0] = `MSF_R_PORT;
    r.port[1] = `MSF_R_PORT;
    r.port[2] = `MSF_R_P2;
    r.sp = `MSF_R_SP;
    return r;
  endfunction

  localparam msf_state_t RST = rst_image();
  localparam int IX_DSEL = 14;
  localparam int IX_IE0 = 25;
  localparam int IX_PSW = 35;
  localparam int IX_PORT0_DIRECTION = 24;
  localparam int IX_PORT1_DIRECTION = 13;
  localparam int IX_PORT2_DIRECTION = 23;

  msf_state_t s_r;
  msf_state_t s_nxt;

  // ****************************************
  // next-state logic
  // ****************************************
  logic [7:0] cur;
  logic [7:0] rv;
  logic [7:0] wv;
  logic wr_ok;
  int gi;

  always_comb begin
    s_nxt = s_r;
    gi = gidx(sfr_addr);
    cur = `MSF_R_ZERO;
    rv = `MSF_R_ZERO;
    // stored value, used for bit merges
    unique case (sfr_addr)
      `MSF_A_P0: cur = s_r.port[0];
      `MSF_A_P1: cur = s_r.port[1];
      `MSF_A_P2: cur = s_r.port[2];
      `MSF_A_SP: cur = s_r.sp;
      `MSF_A_FCTL: cur = {preboot_active, s_r.sec, 4'h0, s_r.meen, s_r.pwe};
      `MSF_A_WDIF: cur = {6'h00, s_r.watchdog_irq_flags};
      `MSF_A_XINT: cur = {1'b0, s_r.int_s};
      default: cur = (gi >= 0) ? s_r.gen[gi] : `MSF_R_ZERO;
    endcase
    // ports read their pins, not the latches
    unique case (sfr_addr)
      `MSF_A_P0: rv = s_r.pin_s[0];
      `MSF_A_P1: rv = s_r.pin_s[1];
      `MSF_A_P2: rv = s_r.pin_s[2];
      default: rv = cur;
    endcase
    // single-bit writes only where the low address bits are zero
    wr_ok = sfr_wr && (!sfr_bit_wr || sfr_addr[2:0] == 3'h0);
    wv = sfr_wdata;
    if (sfr_bit_wr) begin
      wv = cur;
      wv[sfr_bit_sel] = sfr_bit_val;
    end
    // two-stage synchronisers for pins
    s_nxt.pin_m = {port2_pins, port1_pins, port0_pins};
    s_nxt.pin_s = s_r.pin_m;
    s_nxt.int_m = ext_int_pins;
    s_nxt.int_s = s_r.int_m;
    s_nxt.dbg_m = debug_port_en;
    s_nxt.dbg_s = s_r.dbg_m;
    // one-cycle pulses default low
    s_nxt.page_go = 1'b0;
    s_nxt.mass_go = 1'b0;
    s_nxt.ee_go = 1'b0;
    s_nxt.wd_go = 1'b0;
    // read data captured in the cycle of the request
    s_nxt.rvalid = sfr_rd;
    if (sfr_rd) begin
      s_nxt.rdata = rv;
    end
    // stack pointer and program counter
    if (stack_push) begin
      s_nxt.sp = s_r.sp + 8'h01;
    end else if (stack_pop) begin
      s_nxt.sp = s_r.sp - 8'h01;
    end
    if (pc_load) begin
      s_nxt.pc = pc_load_val;
    end else if (pc_fetch) begin
      s_nxt.pc = s_r.pc + 16'h0001;
    end
    // auto clear once a byte went to flash
    if (dptr_ext_wr && s_r.pwe) begin
      s_nxt.pwe = 1'b0;
    end
    // register writes; unmapped addresses fall through untouched
    if (wr_ok) begin
      unique case (sfr_addr)
        `MSF_A_P0: s_nxt.port[0] = wv;
        `MSF_A_P1: s_nxt.port[1] = wv;
        `MSF_A_P2: s_nxt.port[2] = wv;
        `MSF_A_SP: s_nxt.sp = wv;
        `MSF_A_ERASE: begin
          if (wv == `MSF_C_PAGE && s_r.pg_ok) begin
            s_nxt.page_go = 1'b1;
            s_nxt.pg_ok = 1'b0;
          end else if (wv == `MSF_C_MASS && s_r.meen && s_r.dbg_s) begin
            s_nxt.mass_go = 1'b1;
            s_nxt.meen = 1'b0;
          end
        end
        `MSF_A_FCTL: begin
          if (!s_r.gen[IX_IE0][`MSF_F_GIE]) begin
            s_nxt.pwe = wv[`MSF_F_PWE];
          end
          s_nxt.meen = wv[`MSF_F_MEEN];
          s_nxt.sec = s_r.sec | wv[`MSF_F_SEC];
        end
        `MSF_A_WDIF: begin
          s_nxt.watchdog_irq_flags = s_r.watchdog_irq_flags & wv[1:0];
          s_nxt.wd_go = wv[`MSF_F_WDRST];
        end
        `MSF_A_XINT: s_nxt.int_s = s_r.int_m;
        default: begin
          if (gi >= 0) begin
            s_nxt.gen[gi] = wv;
          end
          if (sfr_addr == `MSF_A_PGSEL) begin
            s_nxt.pg_ok = 1'b1;
            s_nxt.epage = wv[6:0];
          end
          if (sfr_addr == `MSF_A_EECMD && wv == `MSF_C_EETX) begin
            s_nxt.ee_go = 1'b1;
          end
        end
      endcase
    end
    // hardware set wins over a clear in the same cycle
    s_nxt.watchdog_irq_flags = s_nxt.watchdog_irq_flags | {one_second_event, engine_transfer_event};
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign sfr_rdata = s_r.rdata;
  assign sfr_rvalid = s_r.rvalid;
  assign port0_out = s_r.port[0];
  assign port1_out = s_r.port[1];
  assign port2_out = s_r.port[2];
  assign port0_oe_n = ~s_r.gen[IX_PORT0_DIRECTION];
  assign port1_oe_n = ~s_r.gen[IX_PORT1_DIRECTION];
  assign port2_oe_n = ~s_r.gen[IX_PORT2_DIRECTION];
  assign stack_pointer = s_r.sp;
  assign program_counter = s_r.pc;
  // working bank base, bank times eight
  assign bank_base = {3'h0, s_r.gen[IX_PSW][`MSF_F_RS_HI:`MSF_F_RS_LO], 3'h0};
  // selected data pointer
  assign active_dptr = s_r.gen[IX_DSEL][0] ? {s_r.gen[3], s_r.gen[2]}
                                           : {s_r.gen[1], s_r.gen[0]};
  assign program_write_enable = s_r.pwe;
  assign read_protect_lock = s_r.sec;
  assign page_erase_start = s_r.page_go;
  assign mass_erase_start = s_r.mass_go;
  assign erase_page = s_r.epage;
  assign eeprom_start = s_r.ee_go;
  assign eeprom_byte_data = s_r.gen[21];
  assign eeprom_command = s_r.gen[22];
  assign watchdog_restart = s_r.wd_go;

  // ****************************************
  // assertions and covers
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  logic wr_sp;
  assign wr_sp = wr_ok && sfr_addr == `MSF_A_SP;

  // counters, erase starts, flash bits, flags, watchdog, ports, bank, eeprom, write decoding
  sp_push_a: assert property (stack_push && !wr_sp |=>
    stack_pointer == $past(stack_pointer) + 8'h01)
    else $error("stack pointer not pre-incremented");
  pc_fetch_a: assert property (pc_fetch && !pc_load |=>
    program_counter == $past(program_counter) + 16'h0001)
    else $error("program counter did not advance");
  page_go_a: assert property (page_erase_start |->
    $past(sfr_wr) && $past(sfr_addr) == `MSF_A_ERASE && $past(sfr_wdata) == `MSF_C_PAGE)
    else $error("page erase without trigger write");
  erase_junk_a: assert property (sfr_wr && !sfr_bit_wr && sfr_addr == `MSF_A_ERASE &&
    sfr_wdata != `MSF_C_PAGE && sfr_wdata != `MSF_C_MASS |=>
    !page_erase_start && !mass_erase_start)
    else $error("erase started by bad code");
  mass_go_a: assert property (mass_erase_start |->
    $past(s_r.dbg_s) && $past(sfr_addr) == `MSF_A_ERASE && $past(sfr_wdata) == `MSF_C_MASS)
    else $error("mass erase without debug port or code");
  pwe_block_a: assert property (s_r.gen[IX_IE0][`MSF_F_GIE] && !dptr_ext_wr |=>
    $stable(program_write_enable))
    else $error("write enable changed with interrupts on");
  pwe_clear_a: assert property (program_write_enable && dptr_ext_wr &&
    !(sfr_wr && sfr_addr == `MSF_A_FCTL) |=>
    !program_write_enable)
    else $error("write enable did not self clear");
  lock_hold_a: assert property (read_protect_lock |=> read_protect_lock)
    else $error("read lock cleared without reset");
  lock_set_a: assert property (sfr_wr && !sfr_bit_wr && sfr_addr == `MSF_A_FCTL &&
    sfr_wdata[`MSF_F_SEC] |=> read_protect_lock)
    else $error("read lock not set by write");
  flag_set_a: assert property (engine_transfer_event |=>
    s_r.watchdog_irq_flags[0] ##1 (s_r.watchdog_irq_flags[0] || $past(sfr_wr)))
    else $error("transfer flag not held");
  wd_kick_a: assert property (sfr_wr && !sfr_bit_wr && sfr_addr == `MSF_A_WDIF &&
    sfr_wdata[`MSF_F_WDRST] |=>
    watchdog_restart ##1 !watchdog_restart)
    else $error("watchdog restart pulse wrong");
  port_read_a: assert property (sfr_rd && sfr_addr == `MSF_A_P1 |->
    ##1 sfr_rdata == $past(s_r.pin_s[1]))
    else $error("port read not from pins");
  latch_out_a: assert property (sfr_wr && !sfr_bit_wr && sfr_addr == `MSF_A_P1 |=>
    port1_out == $past(sfr_wdata))
    else $error("port latch not on pins");
  dir_oe_a: assert property (sfr_wr && !sfr_bit_wr && sfr_addr == `MSF_A_PORT0_DIRECTION |=>
    port0_oe_n == ~$past(sfr_wdata))
    else $error("direction not on output enables");
  bank_sel_a: assert property (wr_ok && !sfr_bit_wr && sfr_addr == `MSF_A_PSW |=>
    bank_base == {3'h0, $past(sfr_wdata[4:3]), 3'h0})
    else $error("bank base does not follow status word");
  ee_start_a: assert property (sfr_wr && !sfr_bit_wr && sfr_addr == `MSF_A_EECMD &&
    sfr_wdata == `MSF_C_EETX |=> eeprom_start && eeprom_command == `MSF_C_EETX)
    else $error("eeprom send not started");
  bit_refuse_a: assert property (sfr_wr && sfr_bit_wr && sfr_addr[2:0] != 3'h0 |=>
    $stable(s_r.gen) && $stable(s_r.port))
    else $error("bit write to byte register took effect");
  unmapped_a: assert property (sfr_wr && gidx(sfr_addr) < 0 |=>
    $stable(s_r.gen))
    else $error("unmapped write changed state");

  page_erase_c: cover property (page_erase_start);
  mass_erase_c: cover property (mass_erase_start);
  eeprom_tx_c: cover property (eeprom_start);
  flag_race_c: cover property (one_second_event && sfr_wr && sfr_addr == `MSF_A_WDIF);
  pwe_clear_c: cover property (program_write_enable && dptr_ext_wr);
endmodule
`default_nettype wire

// file: testbench/msf_core_model.sv
// processor core model issuing direct register reads and writes
`timescale 1ns/1ps
`default_nettype none
module msf_core_model (
  input wire logic clk,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata,
  output logic sfr_bit_wr,
  output logic [2:0] sfr_bit_sel,
  output logic sfr_bit_val,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_rvalid
);
  initial begin
    {sfr_addr, sfr_wr, sfr_rd, sfr_wdata, sfr_bit_wr, sfr_bit_sel, sfr_bit_val} = '0;
  end
  // one access held over one taking edge; entered 2 ns after an edge
  task automatic acc(input logic w, r, b, input logic [7:0] a, d);
    sfr_wr = w;
    sfr_rd = r;
    sfr_bit_wr = b;
    sfr_addr = a;
    sfr_wdata = d;
    @(posedge clk);
    #2;
  endtask
  task automatic wr(input logic [7:0] a, d);
    acc(1'b1, 1'b0, 1'b0, a, d);
  endtask
  task automatic bwr(input logic [7:0] a, input logic [2:0] s, input logic v);
    sfr_bit_sel = s;
    sfr_bit_val = v;
    acc(1'b1, 1'b0, 1'b1, a, ~sfr_wdata);
  endtask
  // read data is taken 2 ns after the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    acc(1'b0, 1'b1, 1'b0, a, ~sfr_wdata);
    d = sfr_rdata;
    v = sfr_rvalid;
  endtask
  // released address and data lines show the inverse of their last value; strobes go low
  task automatic idle();
    acc(1'b0, 1'b0, 1'b0, ~sfr_addr, ~sfr_wdata);
  endtask
endmodule
`default_nettype wire

// file: testbench/msf_sfr_bank_tb.sv
// self-checking testbench of the special function register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); \
  end \
end
module msf_sfr_bank_tb;
  import msf_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, sp, bank_base, ee_dat, ee_cmd;
  logic sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, sfr_rvalid, pwe, lock;
  logic [2:0] sfr_bit_sel;
  logic stack_push = 1'b0, stack_pop = 1'b0, pc_fetch = 1'b0, pc_load = 1'b0;
  logic dptr_ext_wr = 1'b0;
  logic xfer_ev = 1'b0, sec_ev = 1'b0, preboot = 1'b0, dbg_en = 1'b0;
  logic [15:0] pc_load_val = 16'h0000;
  logic [15:0] pc, dptr;
  logic [6:0] ext_int = 7'h00;
  logic [6:0] erase_page;
  logic [7:0] ext_pins = 8'h3C;
  wire logic [2:0][7:0] po, poe, pins;
  logic pg_go, ms_go, ee_go, wd_go;
  int error_cnt = 0, cmp_count = 0, n_pg = 0, n_ms = 0, n_ee = 0, n_wd = 0;
  logic [7:0] rw_a [34] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89,
    8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h92, 8'h98, 8'h99, 8'h9A, 8'h9B, 8'h9C, 8'h9D,
    8'h9E, 8'hA9, 8'hAA, 8'hB7, 8'hB8, 8'hB9, 8'hBA, 8'hBB, 8'hBF, 8'hC0, 8'hD8, 8'hE0,
    8'hF0};
  logic [7:0] rs_a [6] = '{8'h81, 8'h8E, 8'hAA, 8'hBA, 8'hBB, 8'hE0};
  logic [7:0] rs_v [6] = '{8'h07, 8'h01, 8'hD9, 8'h03, 8'h03, 8'h00};
  logic [7:0] pa [3] = '{8'h80, 8'h90, 8'hA0};
  logic [7:0] da [3] = '{8'hA2, 8'h91, 8'hA1};
  // pin level: driven latch where enabled, outside level elsewhere
  assign pins = (po & ~poe) | ({3{ext_pins}} & poe);
  always #25 clk = ~clk;
  // counts of one-cycle start pulses
  always @(posedge clk) begin
    n_pg += int'(pg_go === 1'b1);
    n_ms += int'(ms_go === 1'b1);
    n_ee += int'(ee_go === 1'b1);
    n_wd += int'(wd_go === 1'b1);
  end
  msf_core_model msf_core_model_inst (.clk(clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr),
    .sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val), .sfr_rdata(sfr_rdata),
    .sfr_rvalid(sfr_rvalid));
  msf_sfr_bank msf_sfr_bank_inst (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr),
    .sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val), .sfr_rdata(sfr_rdata),
    .sfr_rvalid(sfr_rvalid), .stack_push(stack_push), .stack_pop(stack_pop),
    .pc_fetch(pc_fetch), .pc_load(pc_load), .pc_load_val(pc_load_val),
    .dptr_ext_wr(dptr_ext_wr), .engine_transfer_event(xfer_ev), .one_second_event(sec_ev),
    .preboot_active(preboot), .debug_port_en(dbg_en), .ext_int_pins(ext_int),
    .port0_pins(pins[0]), .port1_pins(pins[1]), .port2_pins(pins[2]),
    .port0_out(po[0]), .port1_out(po[1]), .port2_out(po[2]), .port0_oe_n(poe[0]),
    .port1_oe_n(poe[1]), .port2_oe_n(poe[2]), .stack_pointer(sp), .program_counter(pc),
    .bank_base(bank_base), .active_dptr(dptr), .program_write_enable(pwe),
    .read_protect_lock(lock), .page_erase_start(pg_go), .mass_erase_start(ms_go),
    .erase_page(erase_page), .eeprom_start(ee_go), .eeprom_byte_data(ee_dat),
    .eeprom_command(ee_cmd), .watchdog_restart(wd_go));
  // ****************************************
  // access tasks
  // ****************************************
  task automatic w(input logic [7:0] a, d);
    msf_core_model_inst.wr(a, d);
  endtask
  task automatic idl(input int n);
    repeat (n) msf_core_model_inst.idle();
  endtask
  task automatic rc(input logic [7:0] a, e);
    logic [7:0] d;
    logic v;
    msf_core_model_inst.rd(a, d, v);
    `CHK("read valid", 1'b1, v);
    `CHK($sformatf("reg %h", a), e, d);
  endtask
  task automatic close_out();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #(5000 * 50);
    error_cnt++;
    close_out();
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    #2;
    resetn = 1'b1;
    `CHK("latches", 24'h00FFFF, po);
    `CHK("enables", 24'hFFFFFF, poe);
    `CHK("pc", 16'h0000, pc);
    foreach (rs_a[i]) rc(rs_a[i], rs_v[i]);
    foreach (rw_a[i]) w(rw_a[i], rw_a[i] ^ 8'h5A);
    foreach (rw_a[i]) rc(rw_a[i], rw_a[i] ^ 8'h5A);
    w(8'h93, 8'hFF);
    rc(8'h93, 8'h00);
    rc(8'h92, 8'h92 ^ 8'h5A);
    w(8'h88, 8'h00);
    msf_core_model_inst.bwr(8'h88, 3'd3, 1'b1);
    rc(8'h88, 8'h08);
    w(8'h89, 8'h00);
    msf_core_model_inst.bwr(8'h89, 3'd3, 1'b1);
    rc(8'h89, 8'h00);
    for (int k = 0; k < 4; k++) begin
      w(8'hD0, 8'(k << 3));
      `CHK("bank", 8'(k << 3), bank_base);
    end
    w(8'h81, 8'h07);
    stack_push = 1'b1;
    idl(1);
    stack_push = 1'b0;
    `CHK("sp push", 8'h08, sp);
    stack_pop = 1'b1;
    idl(1);
    stack_pop = 1'b0;
    `CHK("sp pop", 8'h07, sp);
    pc_fetch = 1'b1;
    idl(2);
    `CHK("pc", 16'h0002, pc);
    pc_load_val = 16'hFFFE;
    pc_load = 1'b1;
    idl(1);
    pc_load = 1'b0;
    idl(2);
    pc_fetch = 1'b0;
    `CHK("pc wrap", 16'h0000, pc);
    for (int i = 0; i < 3; i++) begin
      w(pa[i], 8'h5A);
      w(da[i], 8'hF0);
      `CHK("latch", 8'h5A, po[i]);
      `CHK("enable", 8'h0F, poe[i]);
      idl(3);
      rc(pa[i], 8'h5C);
    end
    w(8'hB7, 8'h05);
    w(8'h94, 8'h33);
    idl(1);
    `CHK("page starts", 0, n_pg);
    w(8'h94, 8'h55);
    `CHK("page", 7'h05, erase_page);
    idl(1);
    `CHK("page starts", 1, n_pg);
    w(8'h94, 8'h55);
    idl(1);
    `CHK("page starts", 1, n_pg);
    w(8'hB2, 8'h02);
    w(8'h94, 8'hAA);
    idl(1);
    `CHK("mass starts", 0, n_ms);
    dbg_en = 1'b1;
    idl(3);
    w(8'hB2, 8'h02);
    w(8'h94, 8'hAA);
    idl(1);
    `CHK("mass starts", 1, n_ms);
    rc(8'hB2, 8'h00);
    w(8'h9E, 8'hC3);
    w(8'h9F, 8'h01);
    `CHK("ee data", 8'hC3, ee_dat);
    `CHK("ee cmd", 8'h01, ee_cmd);
    idl(1);
    `CHK("ee starts", 1, n_ee);
    w(8'hA8, 8'h00);
    w(8'hB2, 8'h01);
    `CHK("pwe", 1'b1, pwe);
    dptr_ext_wr = 1'b1;
    idl(1);
    dptr_ext_wr = 1'b0;
    `CHK("pwe", 1'b0, pwe);
    w(8'hA8, 8'h80);
    w(8'hB2, 8'h01);
    `CHK("pwe", 1'b0, pwe);
    w(8'hA8, 8'h00);
    w(8'hB2, 8'h40);
    w(8'hB2, 8'h00);
    `CHK("lock", 1'b1, lock);
    preboot = 1'b1;
    rc(8'hB2, 8'hC0);
    xfer_ev = 1'b1;
    idl(1);
    xfer_ev = 1'b0;
    rc(8'hE8, 8'h01);
    sec_ev = 1'b1;
    idl(1);
    sec_ev = 1'b0;
    rc(8'hE8, 8'h03);
    w(8'hE8, 8'hFE);
    rc(8'hE8, 8'h02);
    `CHK("restarts", 1, n_wd);
    w(8'hE8, 8'h7D);
    rc(8'hE8, 8'h00);
    `CHK("restarts", 1, n_wd);
    ext_int = 7'h55;
    idl(3);
    rc(8'hF8, 8'h55);
    ext_int = 7'h2A;
    idl(3);
    rc(8'hF8, 8'h2A);
    w(8'h82, 8'h11);
    w(8'h83, 8'h22);
    w(8'h84, 8'h33);
    w(8'h85, 8'h44);
    w(8'h92, 8'h00);
    `CHK("dptr", 16'h2211, dptr);
    w(8'h92, 8'h01);
    `CHK("dptr", 16'h4433, dptr);
    close_out();
  end
endmodule
`default_nettype wire
